// ---- hw/spt_link_if.sv ----
// serial line between the transmitter and the remote receiver
// the bench joins both ends through this interface
`timescale 1ns/1ps
interface spt_link_if;
  logic txLine;
  logic txLineEn;

  modport dev (output txLine, output txLineEn);
  modport far (input txLine, input txLineEn);
endinterface : spt_link_if

// ---- hw/spt_pkg.sv ----
// constants, types and shared decoding for the serial transmitter and its far end
// assumes a single 20 MHz system clock shared by both ends
package spt_pkg;

  localparam int unsigned CLK_PERIOD_NS = 50;

  // avalon word addresses (byte offset is four times the index)
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_BAUD = 2'h3;

  // control register fields
  localparam int CTRL_TRANSMIT_ENABLE  = 0;
  localparam int CTRL_SYNC  = 1;
  localparam int CTRL_PEN   = 2;
  localparam int CTRL_NINE  = 3;
  localparam int CTRL_D9    = 4;
  localparam int CTRL_INV   = 5;
  localparam int CTRL_IE    = 6;
  localparam int CTRL_WIDTH = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // status register fields
  localparam int STAT_BUFEMPTY = 0;
  localparam int STAT_SREMPTY  = 1;

  // baud register fields
  localparam int BAUD_WIDE = 16;
  localparam logic [15:0] BAUD_DIV_RESET  = 16'h0000;
  localparam logic        BAUD_WIDE_RESET = 1'b0;

  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} spt_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spt_rx_e;

  // bit period in clocks: divisor plus one, 8-bit or 16-bit divisor
  function automatic logic [16:0] spt_period(input logic [15:0] div, input logic wide);
    if (wide) begin
      return {1'b0, div} + 17'h00001;
    end
    return {9'h000, div[7:0]} + 17'h00001;
  endfunction : spt_period

endpackage : spt_pkg

// ---- hw/spt_rx_end.sv ----
// remote asynchronous receiver on the serial line
// assumes it is told the same divisor, width and polarity as the transmitter
`timescale 1ns/1ps
module spt_rx_end
  import spt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  spt_link_if.far          link,
  input  wire logic [15:0] cfgDivisor,
  input  wire logic        cfgWide,
  input  wire logic        cfgNine,
  input  wire logic        cfgInvert,
  output logic      [8:0]  rxData,
  output logic             rxValid,
  output logic             rxFrameErr
);

  logic        sync1_ff;
  logic        sync2_ff;
  logic        sync3_ff;
  logic        level_ff;
  spt_rx_e     state_ff;
  logic [16:0] cnt_ff;
  logic [3:0]  bitIdx_ff;
  logic [8:0]  shift_ff;
  logic        nine_ff;
  logic [16:0] period;
  logic        rawLine;
  logic        bitVal;
  logic        bitEnd;

  // an undriven line is taken as mark; polarity is undone before the synchroniser
  // so a polarity change while the driver is off cannot fake a start bit
  assign rawLine = link.txLineEn ? (link.txLine ^ cfgInvert) : 1'b1;
  assign period  = spt_period(cfgDivisor, cfgWide);
  assign bitVal  = level_ff;
  assign bitEnd  = (cnt_ff == period - 17'h00001);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      sync3_ff <= 1'b1;
    end else begin
      sync1_ff <= rawLine;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // a change counts only once two later stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_ff <= 1'b1;
    end else if (sync2_ff == sync3_ff) begin
      level_ff <= sync3_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff   <= RX_IDLE;
      cnt_ff     <= 17'h00000;
      bitIdx_ff  <= 4'h0;
      shift_ff   <= 9'h000;
      nine_ff    <= 1'b0;
      rxData     <= 9'h000;
      rxValid    <= 1'b0;
      rxFrameErr <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      unique case (state_ff)
        RX_IDLE: begin
          cnt_ff <= 17'h00000;
          if (!bitVal) begin
            nine_ff  <= cfgNine;
            state_ff <= RX_START;
          end
        end
        RX_START: begin
          // mid start bit: reject glitches, then align to bit centres
          if (cnt_ff == (period >> 1)) begin
            cnt_ff    <= 17'h00000;
            bitIdx_ff <= 4'h0;
            state_ff  <= bitVal ? RX_IDLE : RX_DATA;
          end else begin
            cnt_ff <= cnt_ff + 17'h00001;
          end
        end
        RX_DATA: begin
          if (bitEnd) begin
            cnt_ff    <= 17'h00000;
            shift_ff  <= {bitVal, shift_ff[8:1]};
            bitIdx_ff <= bitIdx_ff + 4'h1;
            if (bitIdx_ff == (nine_ff ? 4'h8 : 4'h7)) begin
              state_ff <= RX_STOP;
            end
          end else begin
            cnt_ff <= cnt_ff + 17'h00001;
          end
        end
        RX_STOP: begin
          if (bitEnd) begin
            cnt_ff     <= 17'h00000;
            rxData     <= nine_ff ? shift_ff : {1'b0, shift_ff[8:1]};
            rxFrameErr <= ~bitVal;
            rxValid    <= 1'b1;
            state_ff   <= RX_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 17'h00001;
          end
        end
      endcase
    end
  end

endmodule : spt_rx_end

// ---- hw/spt_tx_dev.sv ----
// asynchronous serial transmitter with a one-character holding buffer
// registers are reached over avalon-mm with waitrequest, word addressed;
// drives the serial line through spt_link_if and shares clk with the bus
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps

// Behaviour
// (RULE1) idle line sits at mark level
// (RULE2) start, eight or nine data, stop
// (RULE3) every bit lasts one baud period
// (RULE4) data bits leave least significant first
// (RULE5) baud from 8-bit or 16-bit divider
// (RULE6) same format and rate as receiver
// (RULE7) no hardware parity; software ninth bit
// (RULE8) sends only when enabled, async, port on
// (RULE9) port enable turns on line driver
// (RULE10) write to empty shifter loads at once
// (RULE11) queued character loads right after stop
// (RULE12) frame starts immediately after load
// (RULE13) polarity bit inverts idle and data
// (RULE14) buffer-empty set unless character queued; here also held clear while transmit enable is off
// (RULE15) flag valid two cycles after write
// (RULE16) buffer-empty flag is read-only
// (RULE17) interrupt enable only gates request
// (RULE18) software enables interrupt only while data remains
// (RULE19) shifter-empty clears on load, sets when done
// (RULE20) shifter-empty drives no interrupt
// (RULE21) nine-bit mode sends ninth bit last
// (RULE22) ninth bit captured at buffer write
// (RULE23) exactly one stop bit per character
module spt_tx_dev
  import spt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [1:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  output logic      [31:0] avsReaddata,
  output logic             avsWaitrequest,
  output logic             txIrq,
  spt_link_if.dev          link
);

  logic [6:0]  ctrl_ff;
  logic [15:0] baudDiv_ff;
  logic        baudWide_ff;
  logic        resp_ff;
  logic [8:0]  buf_ff;
  logic        bufFull_ff;
  spt_tx_e     state_ff;
  logic [8:0]  shift_ff;
  logic        nine_ff;
  logic [3:0]  bitIdx_ff;
  logic [16:0] cnt_ff;
  logic        line_ff;

  logic        active;
  logic        wrStrobe;
  logic        bufWrite;
  logic        baudTick;
  logic        loadNow;
  logic        bufEmptyFlag;
  logic        shiftEmpty;
  logic [16:0] period;
  logic [31:0] nxt_readdata;

  // one wait cycle per access; writes land when waitrequest is low
  assign avsWaitrequest = (avsRead | avsWrite) & ~resp_ff;
  assign wrStrobe       = avsWrite & resp_ff;
  assign bufWrite       = wrStrobe & (avsAddress == REG_DATA);

  assign active = ctrl_ff[CTRL_TRANSMIT_ENABLE] & ~ctrl_ff[CTRL_SYNC] & ctrl_ff[CTRL_PEN]; // RULE8

  assign period   = spt_period(baudDiv_ff, baudWide_ff); // RULE5 RULE6
  assign baudTick = (cnt_ff == period - 17'h00001);

  // a queued character loads when the shifter is idle or its stop bit ends
  assign loadNow = active & bufFull_ff &
                   ((state_ff == TX_IDLE) | ((state_ff == TX_STOP) & baudTick)); // RULE10 RULE11

  assign bufEmptyFlag = ctrl_ff[CTRL_TRANSMIT_ENABLE] & ~bufFull_ff; // RULE14 RULE15
  assign shiftEmpty   = (state_ff == TX_IDLE); // RULE19
  assign txIrq        = bufEmptyFlag & ctrl_ff[CTRL_IE]; // RULE17 RULE20

  assign link.txLine   = line_ff;
  assign link.txLineEn = ctrl_ff[CTRL_PEN]; // RULE9

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp_ff <= 1'b0;
    end else begin
      resp_ff <= (avsRead | avsWrite) & ~resp_ff;
    end
  end

  always_comb begin
    nxt_readdata = RD_UNMAPPED;
    unique case (avsAddress)
      REG_CTRL: begin
        nxt_readdata[CTRL_WIDTH-1:0] = ctrl_ff;
      end
      REG_STAT: begin
        // status bits are only ever read; writes here are dropped
        nxt_readdata[STAT_BUFEMPTY] = bufEmptyFlag; // RULE16
        nxt_readdata[STAT_SREMPTY]  = shiftEmpty; // RULE19
      end
      REG_DATA: begin
        nxt_readdata[8:0] = buf_ff;
      end
      REG_BAUD: begin
        nxt_readdata[15:0]      = baudDiv_ff;
        nxt_readdata[BAUD_WIDE] = baudWide_ff;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avsReaddata <= 32'h0000_0000;
    end else if (avsRead & ~resp_ff) begin
      avsReaddata <= nxt_readdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff     <= CTRL_RESET; // RULE13
      baudDiv_ff  <= BAUD_DIV_RESET;
      baudWide_ff <= BAUD_WIDE_RESET;
    end else if (wrStrobe) begin
      if (avsAddress == REG_CTRL) begin
        ctrl_ff <= avsWritedata[CTRL_WIDTH-1:0];
      end
      if (avsAddress == REG_BAUD) begin
        baudDiv_ff  <= avsWritedata[15:0];
        baudWide_ff <= avsWritedata[BAUD_WIDE];
      end
    end
  end

  // holding buffer: the ninth bit is taken from control at write time;
  // a write while a character already waits is dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_ff     <= 9'h000;
      bufFull_ff <= 1'b0;
    end else if (!active) begin
      bufFull_ff <= 1'b0;
    end else if (bufWrite && !bufFull_ff) begin
      buf_ff     <= {ctrl_ff[CTRL_D9], avsWritedata[7:0]}; // RULE22 RULE7
      bufFull_ff <= 1'b1;
    end else if (loadNow) begin
      bufFull_ff <= 1'b0;
    end
  end

  // baud counter restarts on every load so the start bit is a full period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 17'h00000;
    end else if (loadNow || state_ff == TX_IDLE || baudTick) begin
      cnt_ff <= 17'h00000; // RULE3 RULE12
    end else begin
      cnt_ff <= cnt_ff + 17'h00001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff  <= TX_IDLE;
      shift_ff  <= 9'h000;
      nine_ff   <= 1'b0;
      bitIdx_ff <= 4'h0;
    end else if (!active) begin
      state_ff <= TX_IDLE;
    end else if (loadNow) begin
      shift_ff  <= buf_ff;
      nine_ff   <= ctrl_ff[CTRL_NINE]; // RULE21
      bitIdx_ff <= 4'h0;
      state_ff  <= TX_START; // RULE12
    end else if (baudTick) begin
      unique case (state_ff)
        TX_IDLE: begin
          state_ff <= TX_IDLE;
        end
        TX_START: begin
          state_ff <= TX_DATA;
        end
        TX_DATA: begin
          shift_ff  <= {1'b0, shift_ff[8:1]}; // RULE4
          bitIdx_ff <= bitIdx_ff + 4'h1;
          if (bitIdx_ff == (nine_ff ? 4'h8 : 4'h7)) begin
            state_ff <= TX_STOP; // RULE2 RULE21
          end
        end
        TX_STOP: begin
          state_ff <= TX_IDLE; // RULE23
        end
      endcase
    end
  end

  // registered line; polarity applies to idle and data alike
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        TX_IDLE:  line_ff <= ~ctrl_ff[CTRL_INV]; // RULE1 RULE13
        TX_START: line_ff <= ctrl_ff[CTRL_INV]; // RULE2
        TX_DATA:  line_ff <= shift_ff[0] ^ ctrl_ff[CTRL_INV]; // RULE4
        TX_STOP:  line_ff <= ~ctrl_ff[CTRL_INV]; // RULE23
      endcase
    end
  end

endmodule : spt_tx_dev

// ---- tb/spt_link_properties.sv ----
// assertions on the serial link, bus handshake and far-end result of the transmitter pair
// instantiated by the bench beside the link; the bench keeps the bit period at four clocks or more
`timescale 1ns/1ps
module spt_link_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic txLine,
  input wire logic txLineEn,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic avsWaitrequest,
  input wire logic txIrq,
  input wire logic rxValid,
  input wire logic rxFrameErr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_wait_one_cycle: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("waitrequest held beyond one cycle");
  a_no_wait_idle: assert property (!(avsRead || avsWrite) |-> !avsWaitrequest)
    else $error("waitrequest without request");
  a_wait_on_request: assert property ($rose(avsRead || avsWrite) |-> avsWaitrequest)
    else $error("request answered without wait cycle");
  a_bit_hold: assert property (txLineEn && $changed(txLine) |=> $stable(txLine) [*3])
    else $error("line bit shorter than one period");
  a_reset_idle: assert property ($fell(rst) |-> txLine && !txLineEn && !txIrq)
    else $error("line not idle after reset");
  a_no_frame_err: assert property (rxValid |-> !rxFrameErr)
    else $error("stop bit missing");
  a_frame_spacing: assert property (rxValid |=> !rxValid [*8])
    else $error("frames too close");
  a_valid_needs_en: assert property (rxValid |-> txLineEn)
    else $error("character received with driver off");
endmodule : spt_link_properties

// ---- tb/spt_tx_dev_tb.sv ----
// self-checking bench: transmitter and far-end receiver joined by the link interface
// registers reached over avalon-mm; four clock bits, one 16-bit divisor case of 260 clocks
`timescale 1ns/1ps
module spt_tx_dev_tb;
  import spt_pkg::*;
  logic        clk          = 1'b0;
  logic        rst          = 1'b1;
  logic [1:0]  avsAddress   = 2'h0;
  logic        avsRead      = 1'b0;
  logic        avsWrite     = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic        txIrq;
  logic [15:0] cfgDivisor   = 16'h0003;
  logic        cfgWide      = 1'b0;
  logic        cfgNine      = 1'b0;
  logic        cfgInvert    = 1'b0;
  logic [8:0]  rxData;
  logic        rxValid;
  logic        rxFrameErr;
  int          numErrors    = 0;
  int          testsRun     = 0;

  always #25 clk = ~clk;

  spt_link_if spt_link_if_inst ();
  spt_tx_dev spt_tx_dev_inst (.clk(clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .txIrq(txIrq), .link(spt_link_if_inst));
  spt_rx_end spt_rx_end_inst (.clk(clk), .rst(rst), .link(spt_link_if_inst),
    .cfgDivisor(cfgDivisor), .cfgWide(cfgWide), .cfgNine(cfgNine), .cfgInvert(cfgInvert),
    .rxData(rxData), .rxValid(rxValid), .rxFrameErr(rxFrameErr));
  spt_link_properties spt_link_properties_inst (.clk(clk), .rst(rst),
    .txLine(spt_link_if_inst.txLine), .txLineEn(spt_link_if_inst.txLineEn),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWaitrequest(avsWaitrequest),
    .txIrq(txIrq), .rxValid(rxValid), .rxFrameErr(rxFrameErr));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // waitrequest and read data are taken at the rising edge, as the slave sees them
  task automatic bus(input logic [1:0] a, input logic wr, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avsAddress   <= a;
    avsWrite     <= wr;
    avsRead      <= !wr;
    avsWritedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 20);
    q = avsReaddata;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
    if (n >= 20) begin
      numErrors++;
      end_of_test();
    end
  endtask : bus

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic rdchk(input logic [1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    check(q, exp);
  endtask : rdchk

  task automatic wait_rx(input logic [8:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rxValid !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      numErrors++;
      end_of_test();
    end else begin
      check({22'h0, rxFrameErr, rxData}, {23'h0, exp});
    end
  endtask : wait_rx

  task automatic no_rx(input int cycles);
    int seen;
    seen = 0;
    repeat (cycles) begin
      @(negedge clk);
      if (rxValid !== 1'b0) seen++;
    end
    check(seen, 0);
  endtask : no_rx

  task automatic t_send(input logic [31:0] ctrl, input logic [31:0] d, input logic [8:0] exp);
    wr(REG_CTRL, ctrl);
    wr(REG_DATA, d);
    rdchk(REG_STAT, 32'h1);
    wait_rx(exp);
  endtask : t_send

  task automatic t_reset();
    rdchk(REG_CTRL, 32'h0);
    rdchk(REG_BAUD, 32'h0);
    rdchk(REG_STAT, 32'h2);
    check({29'h0, spt_link_if_inst.txLine, spt_link_if_inst.txLineEn, txIrq}, 32'h4);
  endtask : t_reset

  task automatic t_enable();
    wr(REG_BAUD, 32'h3);
    wr(REG_CTRL, 32'h45);
    rdchk(REG_STAT, 32'h3);
    check({30'h0, spt_link_if_inst.txLineEn, txIrq}, 32'h3);
    wr(REG_STAT, 32'h0);
    rdchk(REG_STAT, 32'h3);
  endtask : t_enable

  // third write finds the buffer full and is dropped; the interrupt is switched
  // off once the last character is queued and the flag alone keeps tracking
  task automatic t_back_to_back();
    wr(REG_DATA, 32'h01);
    wr(REG_DATA, 32'h80);
    rdchk(REG_STAT, 32'h0);
    check({31'h0, txIrq}, 32'h0);
    wr(REG_CTRL, 32'h05);
    wr(REG_DATA, 32'hff);
    wait_rx(9'h001);
    wait_rx(9'h080);
    no_rx(60);
    rdchk(REG_STAT, 32'h3);
    check({31'h0, txIrq}, 32'h0);
  endtask : t_back_to_back

  task automatic t_off();
    wr(REG_CTRL, 32'h04);
    rdchk(REG_STAT, 32'h2);
    wr(REG_DATA, 32'h55);
    no_rx(80);
    wr(REG_CTRL, 32'h07);
    wr(REG_DATA, 32'h55);
    rdchk(REG_STAT, 32'h3);
    wr(REG_CTRL, 32'h01);
    wr(REG_DATA, 32'h55);
    rdchk(REG_STAT, 32'h3);
    no_rx(40);
  endtask : t_off

  task automatic t_invert();
    wr(REG_CTRL, 32'h20);
    cfgInvert <= 1'b1;
    // control lands at this edge, the registered line follows one edge later
    repeat (2) @(negedge clk);
    check({31'h0, spt_link_if_inst.txLine}, 32'h0);
    t_send(32'h65, 32'h5a, 9'h05a);
  endtask : t_invert

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_enable();
    t_send(32'h45, 32'ha5, 9'h0a5);
    t_back_to_back();
    cfgNine <= 1'b1;
    t_send(32'h5d, 32'h3c, 9'h13c);
    rdchk(REG_DATA, 32'h13c);
    cfgNine    <= 1'b0;
    cfgWide    <= 1'b1;
    cfgDivisor <= 16'h0103;
    wr(REG_BAUD, 32'h10103);
    t_send(32'h45, 32'h81, 9'h081);
    cfgWide <= 1'b0;
    wr(REG_BAUD, 32'h103);
    t_off();
    t_invert();
    end_of_test();
  end
endmodule : spt_tx_dev_tb
